// ---- rtl/pdte_pkg.sv ----
// constants of the toggle/event status register block
// assumes an 8-bit register port on the device clock
package pdte_pkg;
    localparam logic [7:0] PDTE_ADDR_CTRL = 8'h00;
    localparam logic [7:0] PDTE_ADDR_MASK_A = 8'h0e;
    localparam logic [7:0] PDTE_ADDR_MASK_B = 8'h0f;
    localparam logic [7:0] PDTE_ADDR_STAT_A = 8'h3c;
    localparam logic [7:0] PDTE_ADDR_STAT_B = 8'h3d;
    localparam logic [7:0] PDTE_ADDR_FLAG_A = 8'h3e;
    localparam logic [7:0] PDTE_ADDR_FLAG_B = 8'h3f;
    localparam logic [7:0] PDTE_RESET_VAL = 8'h00;
    localparam logic [7:0] PDTE_CTRL_WMASK = 8'h01;
    localparam logic [7:0] PDTE_MASK_B_WMASK = 8'h01;
    localparam logic [7:0] PDTE_FLAG_B_WMASK = 8'h01;
    localparam int PDTE_CTRL_AUDIO = 0;
    localparam int PDTE_MB_ACK = 0;
    localparam int PDTE_FB_ACK = 0;
    localparam int PDTE_SA_SOFT_RESET_FAILED = 5;
    localparam int PDTE_SA_RETRIES_EXHAUSTED = 4;
    localparam int PDTE_SA_PWR_HI = 3;
    localparam int PDTE_SA_PWR_LO = 2;
    localparam int PDTE_SA_SOFT_RESET_SEEN = 1;
    localparam int PDTE_SA_HARD_RESET_SEEN = 0;
    localparam int PDTE_SB_TOG_HI = 5;
    localparam int PDTE_SB_TOG_LO = 3;
    localparam int PDTE_SB_SOP2DB = 2;
    localparam int PDTE_SB_SOP1DB = 1;
    localparam int PDTE_SB_SOP = 0;
    localparam int PDTE_FA_OCPTEMP = 7;
    localparam int PDTE_FA_TOGDONE = 6;
    localparam int PDTE_FA_SOFT_RESET_FAILED = 5;
    localparam int PDTE_FA_RETRIES_EXHAUSTED = 4;
    localparam int PDTE_FA_HARDSENT = 3;
    localparam int PDTE_FA_TXACK = 2;
    localparam int PDTE_FA_SOFT_RESET_SEEN = 1;
    localparam int PDTE_FA_HARD_RESET_SEEN = 0;
    localparam int PDTE_SYNC_W = 2;
    typedef enum logic [2:0] {
        PDTE_TOG_RUNNING = 3'b000,
        PDTE_TOG_SRC_CC1 = 3'b001,
        PDTE_TOG_SRC_CC2 = 3'b010,
        PDTE_TOG_SNK_CC1 = 3'b101,
        PDTE_TOG_SNK_CC2 = 3'b110,
        PDTE_TOG_AUDIO = 3'b111
    } pdte_tog_t;
    typedef enum logic [2:0] {
        PDTE_SOP = 3'b000,
        PDTE_SOP1 = 3'b001,
        PDTE_SOP2 = 3'b010,
        PDTE_SOP1_DBG = 3'b011,
        PDTE_SOP2_DBG = 3'b100
    } pdte_sop_t;
endpackage

// ---- rtl/pdte_sync.sv ----
// two-stage synchroniser for asynchronous level inputs
// assumes inputs change slowly relative to the clock
`timescale 1ns/10ps
module pdte_sync #(
    parameter int W = 2
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            always_ff @(posedge ref_clk_in or negedge nrst_in)
            begin
                if (!nrst_in)
                begin
                    meta_reg[i] <= 1'b0;
                    sync_out[i] <= 1'b0;
                end
                else
                begin
                    meta_reg[i] <= async_in[i];
                    sync_out[i] <= meta_reg[i];
                end
            end
        end
    endgenerate
endmodule

// ---- rtl/pdte_event_status.sv ----
// event, status and mask registers of the pd port controller
// assumes event inputs are one-cycle pulses on ref_clk_in and
// the register port master runs on the same clock
`timescale 1ns/10ps
module pdte_event_status
    import pdte_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic start_tx_cmd_in,
    input wire logic transmitter_on_cmd_in,
    input wire logic send_hard_reset_cmd_in,
    input wire logic pd_reset_cmd_in,
    input wire logic soft_reset_failed_evt_in,
    input wire logic retries_exhausted_evt_in,
    input wire logic hard_reset_sent_evt_in,
    input wire logic tx_acknowledged_evt_in,
    input wire logic soft_reset_rx_evt_in,
    input wire logic hard_reset_rx_evt_in,
    input wire logic ack_sent_evt_in,
    input wire logic toggle_finished_evt_in,
    input wire logic vconn_overcurrent_in,
    input wire logic overtemp_in,
    input wire logic [1:0] internal_power_request_in,
    input wire logic [3:0] host_power_enables_in,
    input wire logic [2:0] toggle_result_code_in,
    input wire logic rx_fifo_write_in,
    input wire logic [2:0] rx_sop_kind_in,
    input wire logic sink_only_toggle_in,
    input wire logic ra_on_both_cc_in,
    output logic irq_n_out,
    output logic stop_toggle_on_audio_out,
    output logic toggle_audio_halt_out,
    output logic [3:0] effective_power_out
);
    import pdte_pkg::*;

    function automatic logic pdte_hit(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        pdte_hit = (addr == target);
    endfunction

    function automatic logic [3:0] pdte_max_power(
        input logic [3:0] host,
        input logic [1:0] internal
    );
        logic [3:0] merged;
        merged = {internal, host[1:0]};
        pdte_max_power = (host > merged) ? host : merged;
    endfunction

    logic [7:0] ctrl_reg;
    logic [7:0] mask_a_reg;
    logic [7:0] mask_b_reg;
    logic [7:0] flag_a_reg;
    logic [7:0] flag_b_reg;
    logic soft_fail_reg;
    logic retry_fail_reg;
    logic [1:0] int_pwr_reg;
    logic soft_seen_reg;
    logic hard_seen_reg;
    logic [2:0] tog_code_reg;
    logic [2:0] sop_bits_reg;
    logic [PDTE_SYNC_W-1:0] fault_prev_reg;
    logic [PDTE_SYNC_W-1:0] fault_sync;

    logic [7:0] ctrl_next;
    logic [7:0] mask_a_next;
    logic [7:0] mask_b_next;
    logic [7:0] flag_a_next;
    logic [7:0] flag_b_next;
    logic soft_fail_next;
    logic retry_fail_next;
    logic soft_seen_next;
    logic hard_seen_next;
    logic [2:0] sop_bits_next;

    wire wr_ctrl = reg_wr_in && pdte_hit(reg_addr_in, PDTE_ADDR_CTRL);
    wire wr_mask_a = reg_wr_in && pdte_hit(reg_addr_in, PDTE_ADDR_MASK_A);
    wire wr_mask_b = reg_wr_in && pdte_hit(reg_addr_in, PDTE_ADDR_MASK_B);
    wire rd_flag_a = reg_rd_in && pdte_hit(reg_addr_in, PDTE_ADDR_FLAG_A);
    wire rd_flag_b = reg_rd_in && pdte_hit(reg_addr_in, PDTE_ADDR_FLAG_B);

    // fault comparators are analog, so they cross into the clock first
    pdte_sync #(
        .W(PDTE_SYNC_W)
    ) u_fault_sync (
        .ref_clk_in(ref_clk_in),
        .nrst_in(nrst_in),
        .async_in({overtemp_in, vconn_overcurrent_in}),
        .sync_out(fault_sync)
    );

    wire ocp_any = |fault_sync;
    // a rise on either fault counts, so a new fault is not hidden behind one already standing
    wire ocp_rise = |(fault_sync & ~fault_prev_reg);
    wire fail_clr = start_tx_cmd_in || transmitter_on_cmd_in || send_hard_reset_cmd_in;

    logic [7:0] evt_a;
    logic [7:0] evt_b;
    assign evt_a[PDTE_FA_OCPTEMP] = ocp_rise;
    assign evt_a[PDTE_FA_TOGDONE] = toggle_finished_evt_in;
    assign evt_a[PDTE_FA_SOFT_RESET_FAILED] = soft_reset_failed_evt_in;
    assign evt_a[PDTE_FA_RETRIES_EXHAUSTED] = retries_exhausted_evt_in;
    assign evt_a[PDTE_FA_HARDSENT] = hard_reset_sent_evt_in;
    assign evt_a[PDTE_FA_TXACK] = tx_acknowledged_evt_in;
    assign evt_a[PDTE_FA_SOFT_RESET_SEEN] = soft_reset_rx_evt_in;
    assign evt_a[PDTE_FA_HARD_RESET_SEEN] = hard_reset_rx_evt_in;
    assign evt_b = PDTE_FLAG_B_WMASK & {8{ack_sent_evt_in}};

    // read clears, but an event landing on the same edge still sets
    assign flag_a_next = (flag_a_reg & ~{8{rd_flag_a}}) | evt_a;
    assign flag_b_next = (flag_b_reg & ~{8{rd_flag_b}}) | evt_b;

    // reserved bits are never stored, so they always read zero
    assign ctrl_next = wr_ctrl ? (reg_wdata_in & PDTE_CTRL_WMASK) : ctrl_reg;
    assign mask_a_next = wr_mask_a ? reg_wdata_in : mask_a_reg;
    assign mask_b_next = wr_mask_b ? (reg_wdata_in & PDTE_MASK_B_WMASK) : mask_b_reg;

    assign soft_fail_next = soft_reset_failed_evt_in || (soft_fail_reg && !fail_clr);
    assign retry_fail_next = retries_exhausted_evt_in || (retry_fail_reg && !fail_clr);
    assign soft_seen_next = soft_reset_rx_evt_in || (soft_seen_reg && !pd_reset_cmd_in);
    assign hard_seen_next = hard_reset_rx_evt_in || (hard_seen_reg && !pd_reset_cmd_in);

    logic [2:0] sop_decode;
    assign sop_decode[PDTE_SB_SOP2DB] = (rx_sop_kind_in == PDTE_SOP2_DBG);
    assign sop_decode[PDTE_SB_SOP1DB] = (rx_sop_kind_in == PDTE_SOP1_DBG);
    assign sop_decode[PDTE_SB_SOP] = (rx_sop_kind_in == PDTE_SOP);
    assign sop_bits_next = rx_fifo_write_in ? sop_decode : sop_bits_reg;

    logic [7:0] stat_a_view;
    logic [7:0] stat_b_view;
    always_comb
    begin
        stat_a_view = PDTE_RESET_VAL;
        stat_a_view[PDTE_SA_SOFT_RESET_FAILED] = soft_fail_reg;
        stat_a_view[PDTE_SA_RETRIES_EXHAUSTED] = retry_fail_reg;
        stat_a_view[PDTE_SA_PWR_HI:PDTE_SA_PWR_LO] = int_pwr_reg;
        stat_a_view[PDTE_SA_SOFT_RESET_SEEN] = soft_seen_reg;
        stat_a_view[PDTE_SA_HARD_RESET_SEEN] = hard_seen_reg;
        stat_b_view = PDTE_RESET_VAL;
        stat_b_view[PDTE_SB_TOG_HI:PDTE_SB_TOG_LO] = tog_code_reg;
        stat_b_view[PDTE_SB_SOP2DB:PDTE_SB_SOP] = sop_bits_reg;
    end

    logic [7:0] rd_mux;
    always_comb
    begin
        rd_mux = PDTE_RESET_VAL;
        unique case (reg_addr_in)
            PDTE_ADDR_CTRL: rd_mux = ctrl_reg;
            PDTE_ADDR_MASK_A: rd_mux = mask_a_reg;
            PDTE_ADDR_MASK_B: rd_mux = mask_b_reg;
            PDTE_ADDR_STAT_A: rd_mux = stat_a_view;
            PDTE_ADDR_STAT_B: rd_mux = stat_b_view;
            PDTE_ADDR_FLAG_A: rd_mux = flag_a_reg;
            PDTE_ADDR_FLAG_B: rd_mux = flag_b_reg;
            default: rd_mux = PDTE_RESET_VAL;
        endcase
    end

    // mask bit one blocks a flag from the interrupt pin
    wire [7:0] live_a = flag_a_reg & ~mask_a_reg;
    wire [7:0] live_b = flag_b_reg & ~mask_b_reg;
    wire irq_any = (|live_a) || (|live_b);
    wire audio_halt = ctrl_reg[PDTE_CTRL_AUDIO] && sink_only_toggle_in && ra_on_both_cc_in;

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ctrl_reg <= PDTE_RESET_VAL;
            mask_a_reg <= PDTE_RESET_VAL;
            mask_b_reg <= PDTE_RESET_VAL;
            flag_a_reg <= PDTE_RESET_VAL;
            flag_b_reg <= PDTE_RESET_VAL;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            mask_a_reg <= mask_a_next;
            mask_b_reg <= mask_b_next;
            flag_a_reg <= flag_a_next;
            flag_b_reg <= flag_b_next;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            soft_fail_reg <= 1'b0;
            retry_fail_reg <= 1'b0;
            soft_seen_reg <= 1'b0;
            hard_seen_reg <= 1'b0;
            int_pwr_reg <= 2'h0;
            tog_code_reg <= PDTE_TOG_RUNNING;
            sop_bits_reg <= 3'h0;
            fault_prev_reg <= {PDTE_SYNC_W{1'b0}};
        end
        else
        begin
            soft_fail_reg <= soft_fail_next;
            retry_fail_reg <= retry_fail_next;
            soft_seen_reg <= soft_seen_next;
            hard_seen_reg <= hard_seen_next;
            int_pwr_reg <= internal_power_request_in;
            tog_code_reg <= toggle_result_code_in;
            sop_bits_reg <= sop_bits_next;
            fault_prev_reg <= fault_sync;
        end
    end

    always_ff @(posedge ref_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            reg_rdata_out <= PDTE_RESET_VAL;
            reg_rvalid_out <= 1'b0;
            irq_n_out <= 1'b1;
            stop_toggle_on_audio_out <= 1'b0;
            toggle_audio_halt_out <= 1'b0;
            effective_power_out <= 4'h0;
        end
        else
        begin
            if (reg_rd_in)
            begin
                reg_rdata_out <= rd_mux;
            end
            reg_rvalid_out <= reg_rd_in;
            irq_n_out <= !irq_any;
            stop_toggle_on_audio_out <= ctrl_reg[PDTE_CTRL_AUDIO];
            toggle_audio_halt_out <= audio_halt;
            effective_power_out <= pdte_max_power(host_power_enables_in, internal_power_request_in);
        end
    end

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);

    property p_ack_masked;
        flag_b_reg[PDTE_FB_ACK] && mask_b_reg[PDTE_MB_ACK] && (live_a == 8'h00)
            |=> irq_n_out;
    endproperty
    a_ack_masked: assert property (p_ack_masked) else $error("masked ack flag drove irq");

    property p_ack_unmasked;
        flag_b_reg[PDTE_FB_ACK] && !mask_b_reg[PDTE_MB_ACK] |=> !irq_n_out;
    endproperty
    a_ack_unmasked: assert property (p_ack_unmasked) else $error("unmasked ack flag no irq");

    property p_audio_halt;
        ctrl_reg[PDTE_CTRL_AUDIO] && sink_only_toggle_in && ra_on_both_cc_in
            |=> toggle_audio_halt_out;
    endproperty
    a_audio_halt: assert property (p_audio_halt) else $error("audio halt missing");

    property p_soft_reset_failed_set;
        soft_reset_failed_evt_in |=> stat_a_view[PDTE_SA_SOFT_RESET_FAILED] && flag_a_reg[PDTE_FA_SOFT_RESET_FAILED];
    endproperty
    a_soft_reset_failed_set: assert property (p_soft_reset_failed_set) else $error("soft fail not latched");

    property p_retry_set;
        retries_exhausted_evt_in |=> stat_a_view[PDTE_SA_RETRIES_EXHAUSTED] && flag_a_reg[PDTE_FA_RETRIES_EXHAUSTED];
    endproperty
    a_retry_set: assert property (p_retry_set) else $error("retry fail not latched");

    property p_fail_clear;
        fail_clr && !soft_reset_failed_evt_in && !retries_exhausted_evt_in
            |=> !soft_fail_reg && !retry_fail_reg;
    endproperty
    a_fail_clear: assert property (p_fail_clear) else $error("fail bits not cleared");

    property p_power;
        host_power_enables_in == 4'h3 && internal_power_request_in == 2'h3 |=> effective_power_out == 4'hf;
    endproperty
    a_power: assert property (p_power) else $error("merged power wrong");

    property p_tog_code;
        1'b1 |=> stat_b_view[PDTE_SB_TOG_HI:PDTE_SB_TOG_LO] == $past(toggle_result_code_in);
    endproperty
    a_tog_code: assert property (p_tog_code) else $error("toggle code not reported");

    property p_sop;
        rx_fifo_write_in && rx_sop_kind_in == PDTE_SOP
            |=> sop_bits_reg[PDTE_SB_SOP] && !sop_bits_reg[PDTE_SB_SOP1DB] && !sop_bits_reg[PDTE_SB_SOP2DB];
    endproperty
    a_sop: assert property (p_sop) else $error("sop type not flagged");

    property p_read_clear;
        rd_flag_a && evt_a == 8'h00 |=> flag_a_reg == 8'h00 ##1 reg_rdata_out == $past(flag_a_reg, 2);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flag read did not clear");

    property p_ocp;
        $rose(ocp_any) |=> flag_a_reg[PDTE_FA_OCPTEMP];
    endproperty
    a_ocp: assert property (p_ocp) else $error("fault flag missing");

    property p_gcrc;
        ack_sent_evt_in |=> flag_b_reg[PDTE_FB_ACK] && (flag_b_reg & ~PDTE_FLAG_B_WMASK) == 8'h00;
    endproperty
    a_gcrc: assert property (p_gcrc) else $error("ack sent flag missing");

    property p_togdone;
        toggle_finished_evt_in |=> flag_a_reg[PDTE_FA_TOGDONE];
    endproperty
    a_togdone: assert property (p_togdone) else $error("toggle done flag missing");

    property p_hardsent;
        hard_reset_sent_evt_in |=> flag_a_reg[PDTE_FA_HARDSENT];
    endproperty
    a_hardsent: assert property (p_hardsent) else $error("hard reset sent flag missing");

    property p_txack;
        tx_acknowledged_evt_in |=> flag_a_reg[PDTE_FA_TXACK];
    endproperty
    a_txack: assert property (p_txack) else $error("tx acknowledged flag missing");

    property p_soft_rx;
        soft_reset_rx_evt_in |=> flag_a_reg[PDTE_FA_SOFT_RESET_SEEN] && soft_seen_reg;
    endproperty
    a_soft_rx: assert property (p_soft_rx) else $error("soft reset rx not flagged");

    property p_hard_rx;
        hard_reset_rx_evt_in |=> flag_a_reg[PDTE_FA_HARD_RESET_SEEN] && hard_seen_reg;
    endproperty
    a_hard_rx: assert property (p_hard_rx) else $error("hard reset rx not flagged");

    property p_mask_all;
        (flag_a_reg & ~mask_a_reg) == 8'h00 && (flag_b_reg & ~mask_b_reg) == 8'h00 |=> irq_n_out;
    endproperty
    a_mask_all: assert property (p_mask_all) else $error("masked flags drove irq");

    property p_reserved;
        (ctrl_reg & ~PDTE_CTRL_WMASK) == 8'h00 && (mask_b_reg & ~PDTE_MASK_B_WMASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit stored");
endmodule

// ---- tb/pdte_host_model.sv ----
// host processor model: byte reads and writes on the register port
// assumes a same-clock strobe port answering a read one cycle later
`timescale 1ns/10ps
module pdte_host_model (
    input wire logic ref_clk_in,
    input wire logic reg_rvalid_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out
);
    initial
    begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end

    // released lines show the inverse so stale values cannot pass for held ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_wdata_out <= d;
        reg_wr_out <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~a;
        reg_wdata_out <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        reg_addr_out <= a;
        reg_rd_out <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~a;
        @(posedge ref_clk_in);
        while (reg_rvalid_in !== 1'b1 && n < 8)
        begin
            @(posedge ref_clk_in);
            n++;
        end
        d = (reg_rvalid_in === 1'b1) ? reg_rdata_in : 8'hxx;
    endtask
endmodule

// ---- tb/pdte_event_status_bench.sv ----
// self-checking bench of the event and status register block
// assumes the host model owns the register port; events pulse from here
`timescale 1ns/10ps
module pdte_event_status_bench;
    import pdte_pkg::*;
    logic ref_clk_in;
    logic nrst_in;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid, vconn_oc, overtemp, fifo_wr, sink_only, ra;
    logic irq_n, stop_aud, halt;
    logic [11:0] ev;
    logic [1:0] ipwr;
    logic [3:0] hpwr, eff_pwr;
    logic [2:0] tog, sop;
    int n_fail = 0;
    int total_checks = 0;

    pdte_host_model u_pdte_host_model (.ref_clk_in(ref_clk_in), .reg_rvalid_in(reg_rvalid),
        .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr), .reg_wr_out(reg_wr),
        .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd));

    pdte_event_status u_pdte_event_status (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
        .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .reg_rvalid_out(reg_rvalid), .start_tx_cmd_in(ev[8]),
        .transmitter_on_cmd_in(ev[9]), .send_hard_reset_cmd_in(ev[10]), .pd_reset_cmd_in(ev[11]),
        .soft_reset_failed_evt_in(ev[5]), .retries_exhausted_evt_in(ev[4]),
        .hard_reset_sent_evt_in(ev[3]), .tx_acknowledged_evt_in(ev[2]), .soft_reset_rx_evt_in(ev[1]),
        .hard_reset_rx_evt_in(ev[0]), .ack_sent_evt_in(ev[7]), .toggle_finished_evt_in(ev[6]),
        .vconn_overcurrent_in(vconn_oc), .overtemp_in(overtemp), .internal_power_request_in(ipwr),
        .host_power_enables_in(hpwr), .toggle_result_code_in(tog), .rx_fifo_write_in(fifo_wr),
        .rx_sop_kind_in(sop), .sink_only_toggle_in(sink_only), .ra_on_both_cc_in(ra),
        .irq_n_out(irq_n), .stop_toggle_on_audio_out(stop_aud), .toggle_audio_halt_out(halt),
        .effective_power_out(eff_pwr));

    initial
    begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] e);
        total_checks++;
        if (seen !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", w, e, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_pdte_host_model.rd(a, d);
        chk($sformatf("reg %h", a), d, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_pdte_host_model.wr(a, d);
    endtask

    // one-cycle pulse; leaves two edges so the interrupt line has settled
    task automatic pulse(input int i);
        @(posedge ref_clk_in);
        ev <= 12'h001 << i;
        @(posedge ref_clk_in);
        ev <= 12'h000;
        cyc(2);
    endtask

    task automatic t_reset();
        logic [7:0] al[7] = '{8'h00, 8'h0e, 8'h0f, 8'h3c, 8'h3d, 8'h3e, 8'h3f};
        foreach (al[i]) rd_chk(al[i], 8'h00);
        chk("irq_n", {7'h00, irq_n}, 8'h01);
        rd_chk(8'h55, 8'h00);
        wr(8'h00, 8'hff);
        rd_chk(8'h00, 8'h01);
        wr(8'h0f, 8'hfe);
        rd_chk(8'h0f, 8'h00);
        wr(8'h3c, 8'hff);
        rd_chk(8'h3c, 8'h00);
        cyc(1);
        chk("stop_aud", {7'h00, stop_aud}, 8'h01);
    endtask

    task automatic t_audio();
        @(posedge ref_clk_in);
        sink_only <= 1'b1;
        ra <= 1'b1;
        cyc(3);
        chk("halt", {7'h00, halt}, 8'h01);
        wr(8'h00, 8'h00);
        cyc(3);
        chk("halt", {7'h00, halt}, 8'h00);
        chk("stop_aud", {7'h00, stop_aud}, 8'h00);
        @(posedge ref_clk_in);
        sink_only <= 1'b0;
    endtask

    task automatic t_flags();
        for (int i = 0; i < 7; i++)
        begin
            pulse(i);
            chk("irq_n", {7'h00, irq_n}, 8'h00);
            rd_chk(8'h3e, 8'h01 << i);
            rd_chk(8'h3e, 8'h00);
            chk("irq_n", {7'h00, irq_n}, 8'h01);
        end
        @(posedge ref_clk_in);
        vconn_oc <= 1'b1;
        cyc(5);
        rd_chk(8'h3e, 8'h80);
        @(posedge ref_clk_in);
        vconn_oc <= 1'b0;
        overtemp <= 1'b1;
        cyc(5);
        rd_chk(8'h3e, 8'h80);
        @(posedge ref_clk_in);
        overtemp <= 1'b0;
        pulse(7);
        rd_chk(8'h3f, 8'h01);
        rd_chk(8'h3f, 8'h00);
    endtask

    task automatic t_mask();
        wr(8'h0e, 8'hfb);
        pulse(1);
        chk("irq_n", {7'h00, irq_n}, 8'h01);
        pulse(2);
        chk("irq_n", {7'h00, irq_n}, 8'h00);
        rd_chk(8'h3e, 8'h06);
        wr(8'h0e, 8'h00);
        wr(8'h0f, 8'h01);
        pulse(7);
        chk("irq_n", {7'h00, irq_n}, 8'h01);
        rd_chk(8'h3f, 8'h01);
        wr(8'h0f, 8'h00);
        pulse(7);
        cyc(10);
        chk("irq_n", {7'h00, irq_n}, 8'h00);
        rd_chk(8'h3f, 8'h01);
        cyc(2);
        chk("irq_n", {7'h00, irq_n}, 8'h01);
    endtask

    task automatic t_status();
        pulse(11);
        for (int c = 8; c < 11; c++)
        begin
            pulse(5);
            pulse(4);
            rd_chk(8'h3c, 8'h30);
            pulse(c);
            rd_chk(8'h3c, 8'h00);
        end
        rd_chk(8'h3e, 8'h30);
        pulse(1);
        pulse(0);
        rd_chk(8'h3c, 8'h03);
        rd_chk(8'h3e, 8'h03);
        pulse(11);
    endtask

    task automatic t_power();
        logic [3:0] hp[5] = '{4'h3, 4'hf, 4'h8, 4'h5, 4'h1};
        logic [1:0] ip[5] = '{2'h3, 2'h0, 2'h1, 2'h1, 2'h2};
        // higher of host field and {internal, host low two}, worked out by hand
        logic [3:0] ep[5] = '{4'hf, 4'hf, 4'h8, 4'h5, 4'h9};
        foreach (hp[i])
        begin
            @(posedge ref_clk_in);
            hpwr <= hp[i];
            ipwr <= ip[i];
            cyc(3);
            chk("eff_pwr", {4'h0, eff_pwr}, {4'h0, ep[i]});
            rd_chk(8'h3c, {4'h0, ip[i], 2'b00});
        end
    endtask

    task automatic t_toggle();
        logic [2:0] tc[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
        logic [2:0] sk[5] = '{3'h0, 3'h3, 3'h4, 3'h1, 3'h2};
        logic [7:0] se[5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h00};
        foreach (tc[i])
        begin
            @(posedge ref_clk_in);
            tog <= tc[i];
            cyc(3);
            rd_chk(8'h3d, {2'b00, tc[i], 3'b000});
        end
        foreach (sk[i])
        begin
            @(posedge ref_clk_in);
            sop <= sk[i];
            fifo_wr <= 1'b1;
            @(posedge ref_clk_in);
            fifo_wr <= 1'b0;
            rd_chk(8'h3d, se[i] | 8'h38);
        end
    endtask

    // reset in mid-run must drop written and latched state back to zero
    task automatic t_midreset();
        wr(8'h00, 8'h01);
        wr(8'h0e, 8'hfb);
        pulse(2);
        chk("irq_n", {7'h00, irq_n}, 8'h00);
        @(posedge ref_clk_in);
        nrst_in <= 1'b0;
        cyc(2);
        chk("irq_n", {7'h00, irq_n}, 8'h01);
        chk("stop_aud", {7'h00, stop_aud}, 8'h00);
        @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        cyc(2);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h0e, 8'h00);
        rd_chk(8'h3e, 8'h00);
    endtask

    initial
    begin
        #200us;
        n_fail++;
        give_verdict();
    end

    initial
    begin
        nrst_in = 1'b0;
        ev = 12'h000;
        {vconn_oc, overtemp, fifo_wr, sink_only, ra} = 5'h00;
        ipwr = 2'h0;
        hpwr = 4'h0;
        tog = 3'h0;
        sop = 3'h0;
        repeat (8) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        cyc(2);
        t_reset();
        t_audio();
        t_flags();
        t_mask();
        t_status();
        t_power();
        t_toggle();
        t_midreset();
        give_verdict();
    end
endmodule
